// *** common/fcs_pkg.sv ***
/*
 * shared constants and types for the parallel nor flash host controller.
 * assumes one 50 MHz clock and a flash reached only through its pins.
 */
// Overview of operation
// - array reads are plain read cycles with no unlock or command writes
// - every command cycle is a write, except array or identification reads
// - one F0 write returns to array read; issued after id mode or failure
// - identification: AA, 55, 90 at unlock addresses, then a read of the code
// - after polling turns true, take data only on a later read
// - with timeout bit set, recheck polling bit once before declaring failure
package fcs_pkg;
    // flash bus cycle timing, in ns and derived clock cycles
    localparam int CLK_NS = 20;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 60;
    localparam int HOLD_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC = 2;
    // command codes
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // unlock addresses in device units
    localparam logic [19:0] UNLOCK_A_WORD = 20'h00555;
    localparam logic [19:0] UNLOCK_B_WORD = 20'h002AA;
    localparam logic [19:0] UNLOCK_A_BYTE = 20'h00AAA;
    localparam logic [19:0] UNLOCK_B_BYTE = 20'h00555;
    // status bit positions in flash read data
    localparam int POLL_BIT = 7;
    localparam int FAIL_BIT = 5;
    // wishbone register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    // register fields
    localparam int CTRL_BYTE = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_READY = 3;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_RESET = 3'h1,
        OP_AUTOSEL = 3'h2,
        OP_PROGRAM = 3'h3,
        OP_CHIP_ERASE = 3'h4,
        OP_SECTOR_ERASE = 3'h5,
        OP_SUSPEND = 3'h6,
        OP_RESUME = 3'h7
    } fcs_op_e;

    // one flash bus cycle request
    typedef struct packed {
        logic we;
        logic [19:0] addr;
        logic [15:0] data;
    } fcs_req_s;

    // flash pin drive
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [19:0] addr;
        logic [15:0] dq;
        logic dq_oe;
    } fcs_pins_s;
endpackage

// *** hw/fcs_cycle.sv ***
/*
 * one flash read or write bus cycle: setup, strobe, hold.
 * assumes the request is stable only in the cycle of start_i.
 */
`timescale 1ns/100ps
module fcs_cycle
    import fcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire fcs_req_s req_i,
    input wire logic [15:0] dq_i,
    output fcs_pins_s pins_o,
    output logic done_o,
    output logic [15:0] rdata_o
);
    typedef enum logic [3:0] {
        P_IDLE = 4'b0001,
        P_SETUP = 4'b0010,
        P_STROBE = 4'b0100,
        P_HOLD = 4'b1000
    } fcs_phase_e;

    typedef struct packed {
        fcs_phase_e phase;
        logic [3:0] cnt;
        logic we;
        fcs_pins_s pins;
        logic done;
        logic [15:0] rdata;
        logic [15:0] dq_meta;
        logic [15:0] dq_sync;
    } fcs_cycle_s;

    fcs_cycle_s s;
    fcs_cycle_s next_s;

    // phase sequencing; address and data stay put across the strobe
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.dq_meta = dq_i;
        next_s.dq_sync = s.dq_meta;
        case (s.phase)
            P_IDLE: begin
                if (start_i) begin
                    next_s.we = req_i.we;
                    next_s.pins.addr = req_i.addr;
                    next_s.pins.dq = req_i.data;
                    next_s.pins.dq_oe = req_i.we;
                    next_s.cnt = 4'(SETUP_CYC - 1);
                    next_s.phase = P_SETUP;
                end
            end
            P_SETUP: begin
                next_s.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h0) begin
                    // falling edges of chip select and strobe coincide
                    next_s.pins.ce_n = 1'b0;
                    next_s.pins.we_n = ~s.we;
                    next_s.pins.oe_n = s.we;
                    next_s.cnt = s.we ? 4'(STROBE_CYC - 1) : 4'(STROBE_CYC + SYNC_CYC - 1);
                    next_s.phase = P_STROBE;
                end
            end
            P_STROBE: begin
                next_s.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h0) begin
                    if (!s.we) begin
                        next_s.rdata = s.dq_sync;
                    end
                    next_s.pins.ce_n = 1'b1;
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.oe_n = 1'b1;
                    next_s.cnt = 4'(HOLD_CYC - 1);
                    next_s.phase = P_HOLD;
                end
            end
            P_HOLD: begin
                next_s.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h0) begin
                    next_s.pins.dq_oe = 1'b0;
                    next_s.done = 1'b1;
                    next_s.phase = P_IDLE;
                end
            end
            default: begin
                next_s.phase = P_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.phase <= P_IDLE;
            s.pins.ce_n <= 1'b1;
            s.pins.oe_n <= 1'b1;
            s.pins.we_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pins_o = s.pins;
    assign done_o = s.done;
    assign rdata_o = s.rdata;

    // checks on the pin waveform
    a_addr_held: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.pins.ce_n |-> $stable(s.pins.addr) && $stable(s.pins.dq))
        else $error("address or data moved during strobe");
    a_strobe_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(s.pins.we_n) |-> (!s.pins.we_n && !s.pins.ce_n)[*3] ##1 s.pins.we_n)
        else $error("write strobe width wrong");
    a_no_contend: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.pins.oe_n |-> !s.pins.dq_oe && s.pins.we_n)
        else $error("data driven while output enabled");
endmodule

// *** hw/fcs_host.sv ***
/*
 * host controller for a parallel nor flash: wishbone registers in,
 * command sequences and status polling out on the flash pins.
 * assumes a classic wishbone master and a flash with a ready/busy pull-up.
 */
`timescale 1ns/100ps
module fcs_host
    import fcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic [19:0] flash_addr_o,
    output logic flash_word_mode_o,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    input wire logic ready_busy_n_i
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_WR = 7'b0000010,
        S_RD = 7'b0000100,
        S_POLL = 7'b0001000,
        S_CHK = 7'b0010000,
        S_VFY = 7'b0100000,
        S_EXIT = 7'b1000000
    } fcs_state_e;

    typedef struct packed {
        fcs_state_e state;
        fcs_op_e op;
        logic byte_mode;
        logic word_mode;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [2:0] idx;
        logic issued;
        logic done;
        logic fail;
        logic rb_meta;
        logic rb_sync;
        logic ack;
        logic [31:0] dat_o;
    } fcs_host_s;

    fcs_host_s s;
    fcs_host_s next_s;
    logic cyc_start;
    fcs_req_s cyc_req;
    fcs_pins_s pins;
    logic cyc_done;
    logic [15:0] cyc_rdata;

    // device address to pin address; in byte mode bit 0 is the lowest byte lane
    function automatic logic [19:0] pin_addr(input logic [19:0] a, input logic bm);
        return bm ? a : {a[18:0], 1'b0};
    endfunction

    // number of writes in a command sequence
    function automatic logic [2:0] seq_len(input fcs_op_e op);
        case (op)
            OP_READ: return 3'h0;
            OP_AUTOSEL: return 3'h3;
            OP_PROGRAM: return 3'h4;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: return 3'h6;
            default: return 3'h1;
        endcase
    endfunction

    // write cycle idx of a sequence; upper data byte zero outside program data
    function automatic fcs_req_s seq_write(input fcs_op_e op, input logic [2:0] idx, input logic bm,
                                           input logic [19:0] a, input logic [15:0] d);
        logic [19:0] ua;
        logic [19:0] ub;
        fcs_req_s r;
        ua = pin_addr(bm ? UNLOCK_A_BYTE : UNLOCK_A_WORD, bm);
        ub = pin_addr(bm ? UNLOCK_B_BYTE : UNLOCK_B_WORD, bm);
        r.we = 1'b1;
        r.addr = ua;
        r.data = {8'h00, CMD_UNLOCK1};
        case (op)
            OP_RESET: r = '{we: 1'b1, addr: pin_addr(a, bm), data: {8'h00, CMD_RESET}};
            OP_SUSPEND: r = '{we: 1'b1, addr: pin_addr(a, bm), data: {8'h00, CMD_SUSPEND}};
            OP_RESUME: r = '{we: 1'b1, addr: pin_addr(a, bm), data: {8'h00, CMD_RESUME}};
            default: begin
                case (idx)
                    3'h1, 3'h4: r = '{we: 1'b1, addr: ub, data: {8'h00, CMD_UNLOCK2}};
                    3'h2: begin
                        r.data[7:0] = (op == OP_AUTOSEL) ? CMD_AUTOSEL :
                                      (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
                    end
                    3'h3: begin
                        if (op == OP_PROGRAM) begin
                            r = '{we: 1'b1, addr: pin_addr(a, bm), data: d};
                        end
                    end
                    3'h5: begin
                        if (op == OP_CHIP_ERASE) begin
                            r.data = {8'h00, CMD_CHIP};
                        end else begin
                            r = '{we: 1'b1, addr: pin_addr(a, bm), data: {8'h00, CMD_SECTOR}};
                        end
                    end
                    default: r.data = {8'h00, CMD_UNLOCK1};
                endcase
            end
        endcase
        return r;
    endfunction

    // polling bit: true program data or erase-complete one
    function automatic logic poll_pass(input fcs_op_e op, input logic [15:0] d, input logic [15:0] q);
        return (op == OP_PROGRAM) ? (q[POLL_BIT] == d[POLL_BIT]) : q[POLL_BIT];
    endfunction

    // register access and command engine
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.rb_meta = ready_busy_n_i;
        next_s.rb_sync = s.rb_meta;
        cyc_start = 1'b0;
        cyc_req = '0;
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.dat_o = '0;
            if (wb_we_i) begin
                case (wb_adr_i)
                    REG_CTRL: begin
                        if (s.state == S_IDLE && wb_sel_i[0]) begin
                            next_s.op = fcs_op_e'(wb_dat_i[2:0]);
                            next_s.byte_mode = wb_dat_i[CTRL_BYTE];
                            next_s.word_mode = ~wb_dat_i[CTRL_BYTE];
                            next_s.done = 1'b0;
                            next_s.fail = 1'b0;
                            next_s.idx = 3'h0;
                            next_s.issued = 1'b0;
                            // plain read goes straight to a read cycle
                            next_s.state = (fcs_op_e'(wb_dat_i[2:0]) == OP_READ) ? S_RD : S_WR;
                        end
                    end
                    REG_ADDR: begin
                        if (wb_sel_i[0]) next_s.addr[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) next_s.addr[15:8] = wb_dat_i[15:8];
                        if (wb_sel_i[2]) next_s.addr[19:16] = wb_dat_i[19:16];
                    end
                    REG_WDATA: begin
                        if (wb_sel_i[0]) next_s.wdata[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) next_s.wdata[15:8] = wb_dat_i[15:8];
                    end
                    default: ;
                endcase
            end else begin
                case (wb_adr_i)
                    REG_CTRL: next_s.dat_o = {28'h0, s.byte_mode, s.op};
                    REG_ADDR: next_s.dat_o = {12'h0, s.addr};
                    REG_WDATA: next_s.dat_o = {16'h0, s.wdata};
                    REG_STATUS: next_s.dat_o = {28'h0, s.rb_sync, s.fail, s.done, s.state != S_IDLE};
                    REG_RDATA: next_s.dat_o = {16'h0, s.rdata};
                    default: next_s.dat_o = '0;
                endcase
            end
        end
        // request for the current state: sequence writes, reset write or a read
        if (s.state == S_WR) begin
            cyc_req = seq_write(s.op, s.idx, s.byte_mode, s.addr, s.wdata);
        end else if (s.state == S_EXIT) begin
            cyc_req = seq_write(OP_RESET, 3'h0, s.byte_mode, s.addr, s.wdata);
        end else begin
            cyc_req = '{we: 1'b0, addr: pin_addr(s.addr, s.byte_mode), data: 16'h0000};
        end
        if (s.state != S_IDLE && !s.issued) begin
            cyc_start = 1'b1;
            next_s.issued = 1'b1;
        end
        if (cyc_done) begin
            next_s.issued = 1'b0;
            case (s.state)
                S_WR: begin
                    next_s.idx = s.idx + 3'h1;
                    if (s.idx + 3'h1 == seq_len(s.op)) begin
                        case (s.op)
                            OP_AUTOSEL: next_s.state = S_RD;
                            // polling starts after the final strobe rose
                            OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE: next_s.state = S_POLL;
                            default: begin
                                next_s.state = S_IDLE;
                                next_s.done = 1'b1;
                            end
                        endcase
                    end
                end
                S_RD: begin
                    next_s.rdata = cyc_rdata;
                    if (s.op == OP_AUTOSEL) begin
                        next_s.state = S_EXIT;
                    end else begin
                        next_s.state = S_IDLE;
                        next_s.done = 1'b1;
                    end
                end
                S_POLL: begin
                    next_s.rdata = cyc_rdata;
                    if (poll_pass(s.op, s.wdata, cyc_rdata)) begin
                        next_s.state = S_VFY;
                    end else if (cyc_rdata[FAIL_BIT]) begin
                        next_s.state = S_CHK;
                    end
                end
                S_CHK: begin
                    next_s.rdata = cyc_rdata;
                    if (poll_pass(s.op, s.wdata, cyc_rdata)) begin
                        next_s.state = S_VFY;
                    end else begin
                        next_s.fail = 1'b1;
                        next_s.state = S_EXIT;
                    end
                end
                S_VFY: begin
                    next_s.rdata = cyc_rdata;
                    next_s.state = S_IDLE;
                    next_s.done = 1'b1;
                end
                S_EXIT: begin
                    next_s.state = S_IDLE;
                    next_s.done = 1'b1;
                end
                default: next_s.state = S_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.state <= S_IDLE;
            s.op <= OP_READ;
            s.word_mode <= 1'b1;
            s.rb_meta <= 1'b1;
            s.rb_sync <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // flash bus cycle engine
    fcs_cycle u_cycle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(cyc_start),
        .req_i(cyc_req),
        .dq_i(dq_i),
        .pins_o(pins),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata)
    );

    assign wb_dat_o = s.dat_o;
    assign wb_ack_o = s.ack;
    assign flash_ce_n_o = pins.ce_n;
    assign flash_oe_n_o = pins.oe_n;
    assign flash_we_n_o = pins.we_n;
    assign flash_addr_o = pins.addr;
    assign dq_o = pins.dq;
    assign dq_oe_o = pins.dq_oe;
    assign flash_word_mode_o = s.word_mode;

    // sequence checks
    a_read_plain: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_start && s.state == S_RD && s.op == OP_READ && s.idx == 3'h0 |-> !cyc_req.we)
        else $error("plain read preceded by writes");
    a_cmd_writes: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_start && s.state == S_WR |-> cyc_req.we ##1 !cyc_start)
        else $error("command cycle not a write");
    a_reset_code: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_start && s.state == S_EXIT |-> cyc_req.we && cyc_req.data[7:0] == CMD_RESET)
        else $error("exit write is not reset");
    a_fail_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == S_CHK && cyc_done && !poll_pass(s.op, s.wdata, cyc_rdata) |=> s.fail && s.state == S_EXIT)
        else $error("failure did not issue reset");
    a_unlock_first: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_start && s.state == S_WR && s.idx == 3'h0 && seq_len(s.op) > 3'h1
        |-> cyc_req.data[7:0] == CMD_UNLOCK1 && cyc_req.addr == 20'h00AAA)
        else $error("sequence did not open with unlock");
    a_chip_tail: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_start && s.state == S_WR && s.op == OP_CHIP_ERASE && s.idx == 3'h5
        |-> cyc_req.data[7:0] == CMD_CHIP && cyc_req.addr == 20'h00AAA)
        else $error("chip erase last write wrong");
    a_verify_next: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.state == S_POLL || s.state == S_CHK) && cyc_done && poll_pass(s.op, s.wdata, cyc_rdata)
        |=> s.state == S_VFY && cyc_start && !cyc_req.we)
        else $error("no fresh read after polling passed");
    a_recheck: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == S_POLL && cyc_done && !poll_pass(s.op, s.wdata, cyc_rdata) && cyc_rdata[FAIL_BIT]
        |=> s.state == S_CHK && !s.fail)
        else $error("timeout bit not rechecked");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        s.ack |=> !s.ack)
        else $error("ack held two cycles");

    c_program_ok: cover property (@(posedge clk_i) disable iff (rst_i)
        s.state == S_VFY && cyc_done && s.op == OP_PROGRAM);
    c_erase_ok: cover property (@(posedge clk_i) disable iff (rst_i)
        s.state == S_VFY && cyc_done && s.op == OP_SECTOR_ERASE);
    c_fail: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s.fail));
    c_id_exit: cover property (@(posedge clk_i) disable iff (rst_i)
        s.state == S_EXIT && s.op == OP_AUTOSEL && cyc_done);
endmodule

// *** verification/fcs_flash_model.sv ***
/* flash partner model: command decoder, polling status, ready/busy pin.
   assumes clk_i paces the embedded algorithms. */
`timescale 1ns/100ps
module fcs_flash_model #(parameter logic [15:0] ID_CODE = 16'h1234) ( // id value is arbitrary
    input wire logic clk_i, input wire logic ce_n_i, input wire logic oe_n_i, input wire logic we_n_i,
    input wire logic [19:0] addr_i, input wire logic [15:0] dq_i, output logic [15:0] dq_o, output logic rb_n_o
);
    logic [15:0] rd, mem [0:15];
    logic [31:0] h = 0; // last four command bytes
    logic idm = 0, er = 0, p7 = 0, pw = 1, po = 1, tg = 0;
    int busy = 0;
    wire [7:0] d = dq_i[7:0]; // upper data byte ignored in command decode
    wire hit = h == 32'h5580AA55 && (d == 8'h10 || d == 8'h30);
    initial foreach (mem[i]) mem[i] = 16'hFFFF; // erased array
    // decode at the rising write strobe, nothing taken while busy
    always @(posedge clk_i) begin
        pw <= we_n_i;
        po <= oe_n_i;
        if (busy > 0 && !po && oe_n_i) tg <= ~tg; // each status read flips the toggle bit
        if (busy > 0) busy <= busy - 1;
        if (busy == 1 && er) foreach (mem[i]) mem[i] <= 16'hFFFF;
        if (!pw && we_n_i && busy == 0) begin
            h <= {h[23:0], d};
            er <= hit;
            if (hit) busy <= 50;
            else if (h[23:0] == 24'hAA55A0) begin
                mem[addr_i[4:1]] <= mem[addr_i[4:1]] & dq_i;
                p7 <= dq_i[7];
                busy <= 20;
            end else if (h[15:0] == 16'hAA55 && d == 8'h90) idm <= 1;
            else if (d == 8'hF0) idm <= 0;
            else if (d == 8'hB0 || d == 8'h30) idm <= idm; // no erase running: suspend and resume ignored
        end
    end
    // status while busy, codes in id mode, else array data; a released bus shows the inverse
    assign rd = busy > 0 ? {8'h00, er ? 1'b0 : ~p7, tg, 6'h00} : idm ? ID_CODE : mem[addr_i[4:1]];
    assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
    assign rb_n_o = busy == 0;
endmodule

// *** verification/fcs_host_test.sv ***
/* fcs_host bench: wishbone master, flash model, random program data.
   assumes the flash model is compiled first. */
`timescale 1ns/100ps
module fcs_host_test
    import fcs_pkg::*;
;
    localparam logic [15:0] ID = 16'h4321; // arbitrary id value
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, flash_ce_n_o, flash_oe_n_o;
    logic flash_we_n_o, flash_word_mode_o, dq_oe_o, rb_n;
    logic [31:0] wb_dat_i = 0, wb_dat_o, r, seed = 32'hBA0956FC;
    logic [19:0] flash_addr_o;
    logic [15:0] dq_o, mdq, pin, d, a, exp [0:15];
    logic [7:0] wb_adr_i = 0;
    int n_errors = 0, n_compared = 0;
    fcs_host u_fcs_host(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_addr_o, .flash_word_mode_o,
        .dq_i(pin), .dq_o, .dq_oe_o, .ready_busy_n_i(rb_n));
    fcs_flash_model #(.ID_CODE(ID)) u_fcs_flash_model(.clk_i, .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
        .we_n_i(flash_we_n_o), .addr_i(flash_addr_o), .dq_i(pin), .dq_o(mdq), .rb_n_o(rb_n));
    assign pin = dq_oe_o ? dq_o : mdq; // host drives while enabled
    initial forever #10 clk_i = ~clk_i; // 50 MHz clock
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, ad, dt};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic op(input fcs_op_e o);
        wb(1, REG_CTRL, {29'h0, o});
        do wb(0, REG_STATUS, 0); while (r[ST_DONE] !== 1'b1);
        check(r, 32'hA); // done, no failure, pin ready
        check({31'h0, flash_word_mode_o}, 32'h1); // word mode pin
        wb(0, REG_RDATA, 0);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
    // programs, identification, a busy refusal and both erases
    initial begin
        foreach (exp[j]) exp[j] = 16'hFFFF;
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        for (int e = 4; e < 6; e++) begin
            for (int i = 0; i < 3; i++) begin
                seed = lfsr(seed);
                a = {12'h0, seed[3:0]};
                d = seed[31:16] & {8'hFF, exp[a][7], 7'h7F};
                exp[a] = exp[a] & d;
                wb(1, REG_ADDR, {16'h0, a});
                wb(1, REG_WDATA, {16'h0, d});
                op(OP_PROGRAM);
                check(r, {16'h0, exp[a]});
            end
            op(OP_AUTOSEL);
            check(r, {16'h0, ID});
            op(OP_SUSPEND);
            op(OP_READ);
            check(r, {16'h0, exp[a]});
            wb(1, REG_CTRL, 32'(e));
            op(OP_RESUME);
            foreach (exp[j]) exp[j] = 16'hFFFF;
            op(OP_READ);
            check(r, {16'h0, exp[a]});
        end
        complete_run();
    end
endmodule
